// ---- verilog/cop_pkg.sv ----
package cop_pkg;
    // ------------------------------------------------------------
    // Bus encodings
    // ------------------------------------------------------------
    localparam logic       SEL_INSTR      = 1'b0;
    localparam logic       SEL_DATA       = 1'b1;
    localparam logic       DIR_WRITE      = 1'b0;
    localparam logic       DIR_READ       = 1'b1;
    localparam int         CMD_FLAG_BIT   = 7;
    localparam int         LINE_SEL_BIT   = 6;
    localparam int         ADDR_W         = 7;
    localparam int         DATA_W         = 8;
    localparam int         RAM_DEPTH      = 128;
    // ------------------------------------------------------------
    // Panel geometry
    // ------------------------------------------------------------
    localparam logic [6:0] LINE1_FIRST    = 7'h00;
    localparam logic [6:0] LINE1_LAST     = 7'h13;
    localparam logic [6:0] LINE2_FIRST    = 7'h40;
    localparam logic [6:0] LINE2_LAST     = 7'h53;
    localparam logic [6:0] ADDR_RESET     = 7'h00;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int         CLK_MHZ        = 200;
    localparam int         BUSY_NS        = 200;
    localparam int         BUSY_CYCLES    = (BUSY_NS * CLK_MHZ + 999) / 1000;
    localparam int         CNT_W          = 8;

    // Host side of the bus, sampled each clock
    typedef struct packed {
        logic       register_select;
        logic       read_not_write;
        logic       enable;
        logic [7:0] data;
    } cop_bus_in_t;

    // Data lines driven back to the host
    typedef struct packed {
        logic [7:0] data;
        logic       data_oe;
    } cop_bus_out_t;
endpackage

// ---- verilog/cop_ram.sv ----
`timescale 1ns/10ps
module cop_ram #(
    parameter int DEPTH = 128,
    parameter int AW    = 7,
    parameter int DW    = 8
) (
    // Clock
    input  wire logic          i_clk,
    // Port
    input  wire logic          i_we,
    input  wire logic [AW-1:0] i_addr,
    input  wire logic [DW-1:0] i_wdata,
    output logic      [DW-1:0] o_rdata
);
    logic [DW-1:0] mem [DEPTH];

    // Registered read keeps the read path one cycle behind the address
    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[i_addr] <= i_wdata;
        end
        o_rdata <= mem[i_addr];
    end
endmodule

// ---- verilog/cop_char_oled_port.sv ----
`timescale 1ns/10ps
// What this block does
// [RL1] A high register select reaches the character data store, a low one the instruction side.
// [RL2] A high direction line means a read and only then are the data lines driven.
// [RL3] Each write and each counter step is carried out on the falling edge of the enable strobe; read data is driven while enable is high.
// [RL4] An instruction write with bit 7 set loads bits 6 to 0 into the position counter.
// [RL5] First-line columns 1 to 20 sit at addresses 0x00 to 0x13 in ascending order.
// [RL6] Second-line columns 1 to 20 sit at 0x40 to 0x53, bit 6 choosing the line.
// [RL7] An instruction read returns busy on bit 7 and the position counter on bits 6 to 0.
// [RL8] Instructions arriving while busy are dropped; the host polls busy first.
// [RL9] Every data read or write steps the position counter by one, up or down.
// [RL10] The host keeps select, direction and write data steady while enable is high.
module cop_char_oled_port
    import cop_pkg::*;
#(
    parameter int BUSY_LEN = cop_pkg::BUSY_CYCLES
) (
    // Clock and reset
    input  wire logic                  I_REF_CLK,
    input  wire logic                  I_RSTN,
    // Host bus
    input  wire cop_pkg::cop_bus_in_t  I_BUS,
    output cop_pkg::cop_bus_out_t      O_BUS,
    // Direction of auto step, high counts down
    input  wire logic                  I_STEP_DOWN,
    // Panel status
    output logic                       O_BUSY,
    output logic [6:0]                 O_POSITION,
    output logic                       O_POS_LINE2,
    output logic [4:0]                 O_POS_COLUMN,
    output logic                       O_POS_VISIBLE
);
    import cop_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_BUSY = 2'b10
    } cop_state_t;

    cop_state_t       state;
    cop_state_t       next_state;
    logic             en_q;
    logic [6:0]       position_counter;
    logic [6:0]       next_position;
    logic [CNT_W-1:0] busy_cnt;
    logic [7:0]       ram_rdata;

    // ------------------------------------------------------------
    // Strobe decode
    // ------------------------------------------------------------
    // Bus inputs are taken as synchronous, so a single stage edge detect suffices
    wire fall       = en_q && !I_BUS.enable;                                  // [RL3]
    wire is_data    = I_BUS.register_select == SEL_DATA;                      // [RL1]
    wire is_read    = I_BUS.read_not_write == DIR_READ;                       // [RL2]
    wire busy_indication = (state == ST_BUSY);
    wire instr_wr   = fall && !is_data && !is_read && !busy_indication;       // [RL8]
    wire set_pos    = instr_wr && I_BUS.data[CMD_FLAG_BIT];                   // [RL4]
    wire data_xfer  = fall && is_data;                                        // [RL1]
    wire data_wr    = data_xfer && !is_read;
    wire start_busy = instr_wr;
    wire [6:0] stepped = I_STEP_DOWN ? position_counter - 7'h01
                                     : position_counter + 7'h01;              // [RL9]
    wire [7:0] status_word = {busy_indication, position_counter};            // [RL7]
    wire [7:0] read_word   = is_data ? ram_rdata : status_word;
    wire line2      = position_counter[LINE_SEL_BIT];                         // [RL6]
    wire [6:0] col_base = line2 ? LINE2_FIRST : LINE1_FIRST;                  // [RL5]
    wire [6:0] col_off  = position_counter - col_base;
    wire visible    = line2 ? (position_counter <= LINE2_LAST)
                            : (position_counter <= LINE1_LAST);               // [RL5] [RL6]

    always_comb begin
        next_position = position_counter;
        if (set_pos) begin
            next_position = I_BUS.data[6:0];                                  // [RL4]
        end else if (data_xfer) begin
            next_position = stepped;                                          // [RL9]
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (start_busy) begin
                    next_state = ST_BUSY;
                end
            end
            ST_BUSY: begin
                if (busy_cnt == CNT_W'(1)) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            en_q             <= 1'b0;
            state            <= ST_IDLE;
            position_counter <= ADDR_RESET;
        end else begin
            en_q             <= I_BUS.enable;
            state            <= next_state;
            position_counter <= next_position;
        end
    end

    // Only accepted commands reload, so a refused one cannot stretch busy
    always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            busy_cnt <= '0;
        end else if (start_busy) begin
            busy_cnt <= CNT_W'(BUSY_LEN);                                     // [RL8]
        end else if (busy_cnt != '0) begin
            busy_cnt <= busy_cnt - CNT_W'(1);
        end
    end

    // Read data is held while enable is high; the host samples before the fall
    always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_BUS <= '0;
        end else begin
            O_BUS.data_oe <= I_BUS.enable && is_read;                         // [RL2]
            O_BUS.data    <= (I_BUS.enable && is_read) ? read_word : 8'h00;   // [RL7]
        end
    end

    // ------------------------------------------------------------
    // Character store
    // ------------------------------------------------------------
    cop_ram #(
        .DEPTH (RAM_DEPTH),
        .AW    (ADDR_W),
        .DW    (DATA_W)
    ) u_ram (
        .i_clk   (I_REF_CLK),
        .i_we    (data_wr),
        .i_addr  (position_counter),
        .i_wdata (I_BUS.data),
        .o_rdata (ram_rdata)
    );

    // ------------------------------------------------------------
    // Status outputs
    // ------------------------------------------------------------
    assign O_BUSY        = busy_indication;
    assign O_POSITION    = position_counter;
    assign O_POS_LINE2   = line2;
    assign O_POS_COLUMN  = col_off[4:0] + 5'h01;
    assign O_POS_VISIBLE = visible;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_set_position: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN) // [RL4]
        set_pos |=> position_counter == $past(I_BUS.data[6:0]))
        else $error("position not loaded");
    // Busy may end in the same cycle, so watch the counter and not the state
    chk_busy_drops_instr: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN) // [RL8]
        (fall && !is_data && !is_read && busy_indication) |=>
            $stable(position_counter) && busy_cnt == $past(busy_cnt) - CNT_W'(1))
        else $error("instruction accepted while busy");
    chk_busy_starts: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN) // [RL8]
        instr_wr |=> O_BUSY)
        else $error("busy not raised");
    chk_busy_ends: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN) // [RL8]
        $rose(O_BUSY) |-> ##[1:300] !O_BUSY)
        else $error("busy never clears");
    chk_step_up: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN) // [RL9]
        (data_xfer && !I_STEP_DOWN) |=> position_counter == $past(position_counter) + 7'h01)
        else $error("counter did not step up");
    chk_step_down: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN) // [RL9]
        (data_xfer && I_STEP_DOWN) |=> position_counter == $past(position_counter) - 7'h01)
        else $error("counter did not step down");
    chk_drive_read: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN) // [RL2]
        O_BUS.data_oe |-> $past(I_BUS.enable) && $past(I_BUS.read_not_write))
        else $error("bus driven outside read");
    chk_status_word: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN) // [RL7]
        (I_BUS.enable && is_read && !is_data) |=>
            O_BUS.data == {$past(busy_indication), $past(position_counter)})
        else $error("status word wrong");
    chk_edge_only: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN) // [RL3]
        (!fall) |=> $stable(position_counter))
        else $error("counter moved without strobe fall");
    chk_line_map: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN) // [RL6]
        (position_counter == LINE2_LAST) |-> O_POS_LINE2 && O_POS_COLUMN == 5'h14)
        else $error("second line mapping wrong");
    chk_line1_map: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN) // [RL5]
        (position_counter == LINE1_LAST) |-> !O_POS_LINE2 && O_POS_VISIBLE && O_POS_COLUMN == 5'h14)
        else $error("first line mapping wrong");
    chk_line2_first: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN) // [RL6]
        (position_counter == LINE2_FIRST) |-> O_POS_LINE2 && O_POS_VISIBLE && O_POS_COLUMN == 5'h01)
        else $error("second line start wrong");
    chk_data_not_busy: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN) // [RL1]
        (data_xfer && !busy_indication) |=> !O_BUSY)
        else $error("data transfer raised busy");
    chk_read_release: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN) // [RL2]
        (!I_BUS.enable) |=> !O_BUS.data_oe)
        else $error("bus still driven after strobe");
    chk_instr_keeps_pos: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN) // [RL4]
        (instr_wr && !I_BUS.data[CMD_FLAG_BIT]) |=> $stable(position_counter))
        else $error("plain instruction moved counter");
    chk_status_no_step: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN) // [RL7]
        (fall && !is_data && is_read) |=> $stable(position_counter))
        else $error("status read moved counter");
    chk_busy_length: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN) // [RL8]
        $rose(O_BUSY) |-> busy_cnt == CNT_W'(BUSY_LEN))
        else $error("busy length not loaded");

    cov_set_pos:  cover property (@(posedge I_REF_CLK) disable iff (!I_RSTN) set_pos);
    cov_data_wr:  cover property (@(posedge I_REF_CLK) disable iff (!I_RSTN) data_wr);
    cov_stat_rd:  cover property (@(posedge I_REF_CLK) disable iff (!I_RSTN)
        O_BUS.data_oe && O_BUSY);
    cov_line2:    cover property (@(posedge I_REF_CLK) disable iff (!I_RSTN) O_POS_LINE2);
    cov_step_dn:  cover property (@(posedge I_REF_CLK) disable iff (!I_RSTN)
        data_xfer && I_STEP_DOWN);
endmodule

// ---- sim/cop_host_model.sv ----
`timescale 1ns/10ps
module cop_host_model (
    // Clock
    input  wire logic                  i_clk,
    // Bus
    input  wire cop_pkg::cop_bus_out_t i_bus,
    output cop_pkg::cop_bus_in_t       o_bus
);
    import cop_pkg::*;

    initial o_bus = '0;

    // ------------------------------------------------------------
    // One strobed transfer
    // ------------------------------------------------------------
    task automatic xfer(input logic sel, input logic dir, input logic [7:0] wdata,
                        output logic [7:0] rdata, output logic oe);
        @(negedge i_clk);
        o_bus.register_select = sel;
        o_bus.read_not_write  = dir;
        o_bus.data            = wdata;
        o_bus.enable          = 1'b1;
        // Store reads need the longer strobe
        repeat (4) @(negedge i_clk);
        rdata        = i_bus.data;
        oe           = i_bus.data_oe;
        o_bus.enable = 1'b0;
        @(negedge i_clk);
        // Released lines show the inverse, never a stale copy
        o_bus.data = ~wdata;
        @(negedge i_clk);
    endtask
endmodule

// ---- sim/tb_cop_char_oled_port.sv ----
`timescale 1ns/10ps
module tb_cop_char_oled_port;
    import cop_pkg::*;
    localparam int BLEN = 20;
    logic         I_REF_CLK   = 1'b0;
    logic         I_RSTN      = 1'b0;
    logic         I_STEP_DOWN = 1'b0;
    cop_bus_in_t  bus_in;
    cop_bus_out_t bus_out;
    logic         busy;
    logic [6:0]   pos;
    logic         line2;
    logic [4:0]   col;
    logic         vis;
    logic [7:0]   rd;
    logic         oe;
    int           failures = 0;
    int           checked  = 0;

    always #2.5 I_REF_CLK = ~I_REF_CLK;

    cop_char_oled_port #(.BUSY_LEN(BLEN)) i_cop_char_oled_port (
        .I_REF_CLK(I_REF_CLK), .I_RSTN(I_RSTN), .I_BUS(bus_in), .O_BUS(bus_out),
        .I_STEP_DOWN(I_STEP_DOWN), .O_BUSY(busy), .O_POSITION(pos),
        .O_POS_LINE2(line2), .O_POS_COLUMN(col), .O_POS_VISIBLE(vis));
    cop_host_model i_cop_host_model (.i_clk(I_REF_CLK), .i_bus(bus_out), .o_bus(bus_in));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic sel, input logic [7:0] d);
        i_cop_host_model.xfer(sel, DIR_WRITE, d, rd, oe);
        check(8'(oe), 8'h00);
    endtask
    task automatic rdv(input logic sel);
        i_cop_host_model.xfer(sel, DIR_READ, 8'h00, rd, oe);
        check(8'(oe), 8'h01);
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 20; i++) begin
            rdv(SEL_INSTR);
            if (rd[7] === 1'b0) break;
        end
        check(8'(rd[7]), 8'h00);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_set_addr();
        wr(SEL_INSTR, 8'hc5);
        check(8'(pos), 8'h45);
        check(8'(busy), 8'h01);
        rdv(SEL_INSTR);
        check(rd, 8'hc5);
        // Second command lands while still busy
        wr(SEL_INSTR, 8'h90);
        check(8'(pos), 8'h45);
        wait_idle();
        // Instruction without bit 7 only starts busy
        wr(SEL_INSTR, 8'h01);
        check(8'(pos), 8'h45);
        check(8'(busy), 8'h01);
        wait_idle();
    endtask
    task automatic t_lines();
        logic [6:0] tbl [5] = '{LINE1_FIRST, LINE1_LAST, LINE2_FIRST, LINE2_LAST, 7'h14};
        logic       l2;
        logic       v;
        for (int i = 0; i < 5; i++) begin
            l2 = tbl[i][LINE_SEL_BIT];
            v  = (tbl[i] <= LINE1_LAST) || (tbl[i] >= LINE2_FIRST && tbl[i] <= LINE2_LAST);
            wr(SEL_INSTR, {1'b1, tbl[i]});
            check(8'(line2), 8'(l2));
            check(8'(vis), 8'(v));
            if (v) check(8'(col), 8'(tbl[i] - (l2 ? LINE2_FIRST : LINE1_FIRST) + 7'h01));
            wait_idle();
        end
    endtask
    task automatic t_data();
        wr(SEL_INSTR, 8'h90);
        wait_idle();
        wr(SEL_DATA, 8'ha5);
        check(8'(busy), 8'h00);
        wr(SEL_DATA, 8'h5a);
        check(8'(pos), 8'h12);
        wr(SEL_INSTR, 8'h90);
        wait_idle();
        rdv(SEL_DATA);
        check(rd, 8'ha5);
        check(8'(pos), 8'h11);
        @(negedge I_REF_CLK) I_STEP_DOWN = 1'b1;
        rdv(SEL_DATA);
        check(rd, 8'h5a);
        check(8'(pos), 8'h10);
    endtask

    // ------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Whole run is a few hundred cycles; ample margin
    initial begin
        #20000;
        failures++;
        finish_test();
    end

    initial begin
        repeat (4) @(negedge I_REF_CLK);
        check({busy, pos}, 8'h00);
        check({2'b00, vis, col}, 8'h21);
        I_RSTN = 1'b1;
        t_set_addr();
        t_lines();
        t_data();
        finish_test();
    end
endmodule
